// *** verilog/reset_cause_pkg.sv ***
package reset_cause_pkg;

    // ************************************************************
    // Register layout
    // ************************************************************
    localparam int        REG_W          = 8;
    localparam int        POWER_ON_BIT   = 7;
    localparam int        PIN_BIT        = 6;
    localparam int        WATCHDOG_BIT   = 5;
    localparam int        OPCODE_BIT     = 4;
    localparam int        ADDRESS_BIT    = 3;
    localparam int        LOW_VOLT_BIT   = 1;
    localparam int        FORCE_BIT      = 0;
    localparam logic [7:0] CAUSE_RESET   = 8'h82;
    localparam logic [7:0] READ_ZERO     = 8'h00;
    localparam logic [7:0] IMPL_MASK     = 8'hfa;

    // Register selects on the internal bus
    localparam logic [1:0] SEL_NONE      = 2'h0;
    localparam logic [1:0] SEL_CAUSE     = 2'h1;
    localparam logic [1:0] SEL_FORCE     = 2'h2;

endpackage

// *** verilog/reset_cause_and_debug_force_reset.sv ***
// Function
// - Debug force reset clears all cause flags
// - Cause register write restarts watchdog only
// - Power-on sets bits 7 and 1 only
// - Low-voltage sets bit 1, keeps bit 7
// - Other resets latch active sources only
// - Bit 6 reports external pin reset
// - Bit 5 watchdog; blocked when disabled
// - Bit 4 illegal opcode incl gated stop/background_instruction
// - Bit 3 reports illegal address access
// - Low-voltage reset needs enable and trip
// - Force bit written only by debug link
// - Force register always reads zero
// - Force write 1 triggers system reset
`timescale 1ns/1ns
module reset_cause_and_debug_force_reset (
    // Clock and reset
    input  wire logic        ref_clk,
    input  wire logic        srst,
    // Reset sources, levels from same clock domain except pin_reset_n, which is asynchronous
    input  wire logic        power_on_evt,
    input  wire logic        low_voltage_trip,
    input  wire logic        low_voltage_reset_enable,
    input  wire logic        pin_reset_n,
    input  wire logic        watchdog_timeout,
    input  wire logic        watchdog_enable,
    input  wire logic        opcode_illegal,
    input  wire logic        stop_exec,
    input  wire logic        stop_enable,
    input  wire logic        background_instruction,
    input  wire logic        background_mode_enable,
    input  wire logic        address_illegal,
    // Internal bus from user program
    input  wire logic [1:0]  bus_sel,
    input  wire logic        bus_wr,
    input  wire logic        bus_rd,
    input  wire logic [7:0]  bus_wdata,
    output logic      [7:0]  bus_rdata,
    // Background debug write path
    input  wire logic [1:0]  dbg_sel,
    input  wire logic        dbg_wr,
    input  wire logic [7:0]  dbg_wdata,
    // Outputs
    output logic             watchdog_restart,
    output logic             system_reset_req,
    output logic      [7:0]  reset_cause_status
);

    // ************************************************************
    // Source qualification
    // ************************************************************
    logic pin_sync1_ff;
    logic pin_sync2_ff;
    logic lv_reset;
    logic wd_reset;
    logic op_reset;
    logic pin_reset;
    logic force_req;
    logic any_reset;

    // Pin is asynchronous, so two flops before use
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            pin_sync1_ff <= 1'h1;
            pin_sync2_ff <= 1'h1;
        end else begin
            pin_sync1_ff <= pin_reset_n;
            pin_sync2_ff <= pin_sync1_ff;
        end
    end

    assign pin_reset = ~pin_sync2_ff;
    assign lv_reset  = low_voltage_reset_enable & low_voltage_trip;
    assign wd_reset  = watchdog_timeout & watchdog_enable;
    assign op_reset  = opcode_illegal
                     | (stop_exec & ~stop_enable)
                     | (background_instruction & ~background_mode_enable);
    // User writes never reach the force bit
    assign force_req = dbg_wr & (dbg_sel == reset_cause_pkg::SEL_FORCE)
                     & dbg_wdata[reset_cause_pkg::FORCE_BIT];
    assign any_reset = power_on_evt | lv_reset | pin_reset | wd_reset
                     | op_reset | address_illegal | force_req;

    // ************************************************************
    // Cause register
    // ************************************************************
    logic [7:0] cause_ff;
    logic [7:0] nxt_cause;
    logic       rst_req_ff;
    logic       nxt_rst_req;

    always_comb begin
        nxt_cause   = cause_ff;
        nxt_rst_req = any_reset;
        // Priority: power-on, low-voltage, debug force, others
        if (power_on_evt) begin
            nxt_cause = reset_cause_pkg::CAUSE_RESET;
        end else if (lv_reset) begin
            nxt_cause = 8'h00;
            nxt_cause[reset_cause_pkg::POWER_ON_BIT] =
                cause_ff[reset_cause_pkg::POWER_ON_BIT];
            nxt_cause[reset_cause_pkg::LOW_VOLT_BIT] = 1'h1;
        end else if (force_req) begin
            nxt_cause = 8'h00;
        end else if (any_reset) begin
            nxt_cause = 8'h00;
            nxt_cause[reset_cause_pkg::PIN_BIT]      = pin_reset;
            nxt_cause[reset_cause_pkg::WATCHDOG_BIT] = wd_reset;
            nxt_cause[reset_cause_pkg::OPCODE_BIT]   = op_reset;
            nxt_cause[reset_cause_pkg::ADDRESS_BIT]  = address_illegal;
        end
        // Bus writes never alter stored flags
        nxt_cause = nxt_cause & reset_cause_pkg::IMPL_MASK;
    end

    // Flags survive srst; only causes above change them
    // No reset value: unknown until the first power-on, force or other-source reset event
    always_ff @(posedge ref_clk) begin
        cause_ff <= nxt_cause;
        if (srst) begin
            rst_req_ff <= 1'h0;
        end else begin
            rst_req_ff <= nxt_rst_req;
        end
    end

    assign reset_cause_status = cause_ff;
    assign system_reset_req   = rst_req_ff;
    assign watchdog_restart   = bus_wr
                              & (bus_sel == reset_cause_pkg::SEL_CAUSE);

    // ************************************************************
    // Read data
    // ************************************************************
    logic [7:0] rdata_ff;
    logic [7:0] nxt_rdata;

    always_comb begin
        // Force register and unmapped addresses read zero
        nxt_rdata = reset_cause_pkg::READ_ZERO;
        if (bus_rd && bus_sel == reset_cause_pkg::SEL_CAUSE) begin
            nxt_rdata = cause_ff & reset_cause_pkg::IMPL_MASK;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            rdata_ff <= 8'h00;
        end else begin
            rdata_ff <= nxt_rdata;
        end
    end

    assign bus_rdata = rdata_ff;

    // ************************************************************
    // Assertions
    // ************************************************************
    property p_force_clears;
        @(posedge ref_clk) disable iff (srst)
        (force_req && !power_on_evt && !lv_reset) |=> (cause_ff == 8'h00);
    endproperty
    a_force_clears: assert property (p_force_clears)
        else $error("force reset did not clear flags");

    property p_wr_keeps;
        @(posedge ref_clk) disable iff (srst)
        (bus_wr && !any_reset) |=> $stable(cause_ff);
    endproperty
    a_wr_keeps: assert property (p_wr_keeps)
        else $error("bus write changed cause flags");

    property p_por;
        @(posedge ref_clk) disable iff (srst)
        power_on_evt |=> (cause_ff == 8'h82);
    endproperty
    a_por: assert property (p_por)
        else $error("power-on flags wrong");

    property p_lv;
        @(posedge ref_clk) disable iff (srst)
        (lv_reset && !power_on_evt) |=> (cause_ff[1] &&
            cause_ff[7] == $past(cause_ff[7]) && cause_ff[6:3] == 4'h0);
    endproperty
    a_lv: assert property (p_lv)
        else $error("low-voltage flags wrong");

    property p_other;
        @(posedge ref_clk) disable iff (srst)
        (any_reset && !power_on_evt && !lv_reset && !force_req) |=>
            (cause_ff[7] == 1'h0 && cause_ff[1] == 1'h0 &&
             cause_ff[6] == $past(pin_reset) &&
             cause_ff[5] == $past(wd_reset) &&
             cause_ff[4] == $past(op_reset) &&
             cause_ff[3] == $past(address_illegal));
    endproperty
    a_other: assert property (p_other)
        else $error("other reset flags wrong");

    property p_wd_block;
        @(posedge ref_clk) disable iff (srst)
        (!watchdog_enable && !power_on_evt) |=> !cause_ff[5] ||
            $stable(cause_ff[5]);
    endproperty
    a_wd_block: assert property (p_wd_block)
        else $error("watchdog flag set while disabled");

    property p_user_force;
        @(posedge ref_clk) disable iff (srst)
        (!dbg_wr && !power_on_evt && !lv_reset && !pin_reset &&
         !wd_reset && !op_reset && !address_illegal) |=> !system_reset_req;
    endproperty
    a_user_force: assert property (p_user_force)
        else $error("reset without a source");

    property p_read_zero;
        @(posedge ref_clk) disable iff (srst)
        (bus_sel != reset_cause_pkg::SEL_CAUSE) |=> (bus_rdata == 8'h00);
    endproperty
    a_read_zero: assert property (p_read_zero)
        else $error("force register read nonzero");

    property p_force_rst;
        @(posedge ref_clk) disable iff (srst)
        force_req |=> system_reset_req;
    endproperty
    a_force_rst: assert property (p_force_rst)
        else $error("force write did not reset");

    property p_unused;
        @(posedge ref_clk) disable iff (srst)
        ##1 (cause_ff[2] == 1'h0 && cause_ff[0] == 1'h0);
    endproperty
    a_unused: assert property (p_unused)
        else $error("unused bits set");

    // ************************************************************
    // Per-source, watchdog restart and bus access checks
    // ************************************************************
    // A lower cause only shows when no higher one wins the cycle
    logic no_higher_cause;

    assign no_higher_cause = ~power_on_evt & ~lv_reset & ~force_req;

    property p_restart_sel;
        @(posedge ref_clk) disable iff (srst)
        watchdog_restart |->
            (bus_wr && bus_sel == reset_cause_pkg::SEL_CAUSE);
    endproperty
    a_restart_sel: assert property (p_restart_sel)
        else $error("watchdog restart without cause write");

    property p_pin;
        @(posedge ref_clk) disable iff (srst)
        (pin_reset && no_higher_cause) |=>
            cause_ff[reset_cause_pkg::PIN_BIT];
    endproperty
    a_pin: assert property (p_pin)
        else $error("pin flag not set");

    property p_opcode;
        @(posedge ref_clk) disable iff (srst)
        (((stop_exec && !stop_enable) ||
          (background_instruction && !background_mode_enable)) &&
         no_higher_cause) |=> cause_ff[reset_cause_pkg::OPCODE_BIT];
    endproperty
    a_opcode: assert property (p_opcode)
        else $error("gated instruction not flagged illegal");

    property p_stop_legal;
        @(posedge ref_clk) disable iff (srst)
        (any_reset && no_higher_cause && !opcode_illegal &&
         !(background_instruction && !background_mode_enable) &&
         stop_exec && stop_enable) |=>
            !cause_ff[reset_cause_pkg::OPCODE_BIT];
    endproperty
    a_stop_legal: assert property (p_stop_legal)
        else $error("enabled stop flagged illegal");

    property p_address;
        @(posedge ref_clk) disable iff (srst)
        (address_illegal && no_higher_cause) |=>
            cause_ff[reset_cause_pkg::ADDRESS_BIT];
    endproperty
    a_address: assert property (p_address)
        else $error("address flag not set");

    property p_lv_enable;
        @(posedge ref_clk) disable iff (srst)
        (!low_voltage_reset_enable && !power_on_evt) |=>
            !$rose(cause_ff[reset_cause_pkg::LOW_VOLT_BIT]);
    endproperty
    a_lv_enable: assert property (p_lv_enable)
        else $error("low-voltage flag set while disabled");

    property p_user_wr;
        @(posedge ref_clk) disable iff (srst)
        (bus_wr && !dbg_wr && !power_on_evt && !lv_reset && !pin_reset &&
         !wd_reset && !op_reset && !address_illegal) |=>
            (!system_reset_req && $stable(cause_ff));
    endproperty
    a_user_wr: assert property (p_user_wr)
        else $error("user write caused reset or flag change");

    property p_rd_cause;
        @(posedge ref_clk) disable iff (srst)
        (bus_rd && bus_sel == reset_cause_pkg::SEL_CAUSE) |=>
            (bus_rdata == $past(cause_ff) &&
             bus_rdata[2] == 1'h0 && bus_rdata[0] == 1'h0);
    endproperty
    a_rd_cause: assert property (p_rd_cause)
        else $error("cause read data wrong");

endmodule // reset_cause_and_debug_force_reset

// *** sim/debug_host.sv ***
`timescale 1ns/1ns
module debug_host (
    // Clock
    input  wire logic       ref_clk,
    // Debug link
    output logic      [1:0] dbg_sel,
    output logic            dbg_wr,
    output logic      [7:0] dbg_wdata,
    output logic            debug_mode_select_pin
);
    initial begin
        dbg_sel = 2'h0;
        dbg_wr = 1'h0;
        dbg_wdata = 8'h00;
        debug_mode_select_pin = 1'h1;
    end
    // Released data shows the inverse, never a stale copy
    // Mode pin: high picks user mode, low background debug mode
    task automatic put(input logic [7:0] d, input logic m);
        @(negedge ref_clk);
        dbg_sel = 2'h2;
        dbg_wr = 1'h1;
        dbg_wdata = d;
        @(negedge ref_clk);
        dbg_sel = 2'h0;
        dbg_wr = 1'h0;
        dbg_wdata = ~d;
        debug_mode_select_pin = m;
    endtask
endmodule // debug_host

// *** sim/reset_cause_and_debug_force_reset_tb.sv ***
`timescale 1ns/1ns
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin \
    n_mismatch++; $display("[ERR] %0t got %h exp %h", $time, a, b); end end
module reset_cause_and_debug_force_reset_tb;
    logic        ref_clk, srst, power_on_evt, bus_wr, bus_rd;
    logic        dbg_wr, restart, req, mode_pin;
    logic [10:0] src;
    logic [1:0]  bus_sel, dbg_sel;
    logic [7:0]  bus_wdata, bus_rdata, dbg_wdata, flags;
    int          n_mismatch, comparisons;

    debug_host i_host (.ref_clk(ref_clk), .dbg_sel(dbg_sel),
        .dbg_wr(dbg_wr), .dbg_wdata(dbg_wdata),
        .debug_mode_select_pin(mode_pin));

    // Source vector: lv trip, lv en, pin, wd, wd en, op, stop, stop en,
    // background_instruction, background_instruction en, address
    reset_cause_and_debug_force_reset i_dut (.ref_clk(ref_clk),
        .srst(srst), .power_on_evt(power_on_evt),
        .low_voltage_trip(src[10]), .low_voltage_reset_enable(src[9]),
        .pin_reset_n(~src[8]), .watchdog_timeout(src[7]),
        .watchdog_enable(src[6]), .opcode_illegal(src[5]),
        .stop_exec(src[4]), .stop_enable(src[3]),
        .background_instruction(src[2]),
        .background_mode_enable(src[1]), .address_illegal(src[0]),
        .bus_sel(bus_sel), .bus_wr(bus_wr), .bus_rd(bus_rd),
        .bus_wdata(bus_wdata), .bus_rdata(bus_rdata),
        .dbg_sel(dbg_sel), .dbg_wr(dbg_wr), .dbg_wdata(dbg_wdata),
        .watchdog_restart(restart), .system_reset_req(req),
        .reset_cause_status(flags));

    // ****************************************
    // Bus tasks
    // ****************************************
    task automatic tick(input int n);
        repeat (n) @(negedge ref_clk);
    endtask
    task automatic rd(input logic [1:0] s, input logic [7:0] e);
        tick(1);
        bus_sel = s;
        bus_rd = 1'h1;
        tick(1);
        bus_rd = 1'h0;
        `CHK(bus_rdata, e)
    endtask
    task automatic wr(input logic [1:0] s, input logic [7:0] d);
        tick(1);
        bus_sel = s;
        bus_wr = 1'h1;
        bus_wdata = d;
        #1 `CHK(restart, s == 2'h1)
        tick(1);
        bus_wr = 1'h0;
    endtask
    // Source held long enough to pass the pin synchroniser
    task automatic run(input logic [10:0] v, input logic [7:0] e,
                       input logic f);
        if (f) begin
            i_host.put(8'h01, 1'h1);
            `CHK(flags, 8'h00)
            `CHK(req, 1'h1)
        end
        tick(1);
        src = v;
        tick(4);
        `CHK(req, e != 8'h00)
        src = 11'h000;
        tick(4);
        rd(2'h1, e);
        `CHK(flags, e)
        $display("case %h done", v);
    endtask
    task automatic conclude;
        $display("compares %0d mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    initial begin
        ref_clk = 1'h0;
        forever #50 ref_clk = ~ref_clk;
    end
    initial begin
        #2000000;
        n_mismatch++;
        conclude();
    end
    initial begin
        srst = 1'h1;
        power_on_evt = 1'h0;
        src = 11'h000;
        bus_sel = 2'h0;
        bus_wr = 1'h0;
        bus_rd = 1'h0;
        bus_wdata = 8'h00;
        tick(6);
        srst = 1'h0;
        power_on_evt = 1'h1;
        tick(1);
        power_on_evt = 1'h0;
        tick(2);
        `CHK(flags, 8'h82)
        $display("power-on done");
        run(11'h600, 8'h82, 1'h0);
        wr(2'h1, 8'hff);
        rd(2'h1, 8'h82);
        $display("cause write done");
        run(11'h0c0, 8'h20, 1'h0);
        run(11'h080, 8'h00, 1'h1);
        run(11'h020, 8'h10, 1'h1);
        run(11'h010, 8'h10, 1'h1);
        run(11'h018, 8'h00, 1'h1);
        run(11'h019, 8'h08, 1'h1);
        run(11'h004, 8'h10, 1'h1);
        run(11'h006, 8'h00, 1'h1);
        run(11'h001, 8'h08, 1'h1);
        run(11'h100, 8'h40, 1'h1);
        run(11'h0c1, 8'h28, 1'h1);
        run(11'h400, 8'h00, 1'h1);
        run(11'h600, 8'h02, 1'h1);
        wr(2'h2, 8'h01);
        `CHK(req, 1'h0)
        rd(2'h2, 8'h00);
        rd(2'h3, 8'h00);
        i_host.put(8'hfe, 1'h0);
        `CHK(req, 1'h0)
        `CHK(flags, 8'h02)
        $display("debug access done");
        // Mid-run reset: flags kept, request and read data held low
        srst = 1'h1;
        bus_sel = 2'h1;
        bus_rd = 1'h1;
        tick(2);
        `CHK(req, 1'h0)
        `CHK(bus_rdata, 8'h00)
        srst = 1'h0;
        bus_rd = 1'h0;
        rd(2'h1, 8'h02);
        `CHK(flags, 8'h02)
        $display("mid-run reset done");
        conclude();
    end
endmodule // reset_cause_and_debug_force_reset_tb
